// ===== hw/dgr_pkg.sv
package dgr_pkg;

  // byte-wide i/o port map
  localparam logic [15:0] PORT_ATTR_W = 16'h03c0;
  localparam logic [15:0] PORT_ATTR_R = 16'h03c1;
  localparam logic [15:0] PORT_MISC_W_ISR0 = 16'h03c2;
  localparam logic [15:0] PORT_SEQ_IDX = 16'h03c4;
  localparam logic [15:0] PORT_SEQ_DATA = 16'h03c5;
  localparam logic [15:0] PORT_FC_R = 16'h03ca;
  localparam logic [15:0] PORT_MISC_R = 16'h03cc;
  localparam logic [15:0] PORT_GFX_IDX = 16'h03ce;
  localparam logic [15:0] PORT_GFX_DATA = 16'h03cf;
  localparam logic [15:0] PORT_CRTC_IDX_MONO = 16'h03b4;
  localparam logic [15:0] PORT_CRTC_DATA_MONO = 16'h03b5;
  localparam logic [15:0] PORT_ISR1_MONO = 16'h03ba;
  localparam logic [15:0] PORT_CRTC_IDX_COLOR = 16'h03d4;
  localparam logic [15:0] PORT_CRTC_DATA_COLOR = 16'h03d5;
  localparam logic [15:0] PORT_ISR1_COLOR = 16'h03da;

  // misc_output_control fields
  localparam int MISC_RANGE_BIT = 0;
  localparam int MISC_MEM_EN_BIT = 1;
  localparam int MISC_CLK_LO = 2;
  localparam int MISC_CLK_HI = 3;
  localparam int MISC_PAGE_BIT = 5;
  localparam logic [7:0] MISC_RESET = 8'h00;

  // feature control: bit 3 vsync mode, bits 1:0 plain storage
  localparam int FC_VSYNC_OR_BIT = 3;
  localparam logic [7:0] FC_WR_MASK = 8'h0b;
  localparam logic [7:0] FC_RESET = 8'h00;

  // status register fields
  localparam int ISR0_IRQ_BIT = 7;
  localparam int ISR0_SENSE_BIT = 4;
  localparam int ISR1_DIAG_LO = 4;
  localparam int ISR1_DIAG_HI = 5;
  localparam int ISR1_VRETRACE_BIT = 3;
  localparam int ISR1_DISP_OFF_BIT = 0;

  // power-on configuration
  localparam int CFG_CLK_LOCK_BIT = 3;
  localparam logic [7:0] CFG_RESET = 8'h00;

  // extended registers behind the graphics data port
  localparam logic [7:0] EXT_IDX_FIRST = 8'h09;
  localparam logic [7:0] EXT_IDX_LAST = 8'h0f;
  localparam int EXT_COUNT = 7;
  localparam logic [7:0] EXT_IDX_MEMSIZE = 8'h0b;
  localparam int MEMSIZE_PAGE_LOCK_LO = 6;
  localparam int MEMSIZE_PAGE_LOCK_HI = 7;
  localparam logic [7:0] EXT_RESET = 8'h00;

  localparam logic [7:0] IDX_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  typedef enum logic [3:0] {
    DGR_P_NONE,
    DGR_P_ATTR_W,
    DGR_P_ATTR_R,
    DGR_P_MISC_W_ISR0,
    DGR_P_SEQ_IDX,
    DGR_P_SEQ_DATA,
    DGR_P_FC_R,
    DGR_P_MISC_R,
    DGR_P_GFX_IDX,
    DGR_P_GFX_DATA,
    DGR_P_CRTC_IDX,
    DGR_P_CRTC_DATA,
    DGR_P_ISR1_FC_W
  } dgr_port_t;

  typedef enum logic [2:0] {
    DGR_G_NONE,
    DGR_G_SEQ,
    DGR_G_CRTC,
    DGR_G_GFX,
    DGR_G_ATTR
  } dgr_grp_t;

  typedef enum logic [1:0] {
    DGR_CLK_A,
    DGR_CLK_B,
    DGR_CLK_USER
  } dgr_dotclk_t;

  // one host i/o cycle, presented for a single clock
  typedef struct packed {
    logic [15:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } dgr_io_req_t;

  // access forwarded to a register group held outside this block
  typedef struct packed {
    dgr_grp_t grp;
    logic [7:0] index;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } dgr_grp_acc_t;

endpackage

// ===== hw/dgr_port_decode.sv
`timescale 1ns/1ps
// maps a host port number onto a target; the range bit moves the
// timing-controller pair and the status/feature port between bases
module dgr_port_decode (
  input wire logic [15:0] addr_i,
  input wire logic color_i,
  output dgr_pkg::dgr_port_t port_o
);

  logic [15:0] crtc_idx;
  logic [15:0] crtc_data;
  logic [15:0] isr1_port;

  // relocated ports follow the address-range bit
  always_comb begin
    crtc_idx = color_i ? dgr_pkg::PORT_CRTC_IDX_COLOR : dgr_pkg::PORT_CRTC_IDX_MONO; // [RQ2]
    crtc_data = color_i ? dgr_pkg::PORT_CRTC_DATA_COLOR : dgr_pkg::PORT_CRTC_DATA_MONO; // [RQ2]
    isr1_port = color_i ? dgr_pkg::PORT_ISR1_COLOR : dgr_pkg::PORT_ISR1_MONO; // [RQ3]
  end

  // the enable port of the video subsystem is left undecoded on purpose
  always_comb begin
    if (addr_i == crtc_idx) begin
      port_o = dgr_pkg::DGR_P_CRTC_IDX;
    end else if (addr_i == crtc_data) begin
      port_o = dgr_pkg::DGR_P_CRTC_DATA;
    end else if (addr_i == isr1_port) begin
      port_o = dgr_pkg::DGR_P_ISR1_FC_W;
    end else begin
      case (addr_i)
        dgr_pkg::PORT_ATTR_W: port_o = dgr_pkg::DGR_P_ATTR_W; // [RQ13]
        dgr_pkg::PORT_ATTR_R: port_o = dgr_pkg::DGR_P_ATTR_R; // [RQ13]
        dgr_pkg::PORT_MISC_W_ISR0: port_o = dgr_pkg::DGR_P_MISC_W_ISR0; // [RQ1]
        dgr_pkg::PORT_SEQ_IDX: port_o = dgr_pkg::DGR_P_SEQ_IDX; // [RQ13]
        dgr_pkg::PORT_SEQ_DATA: port_o = dgr_pkg::DGR_P_SEQ_DATA; // [RQ13]
        dgr_pkg::PORT_FC_R: port_o = dgr_pkg::DGR_P_FC_R;
        dgr_pkg::PORT_MISC_R: port_o = dgr_pkg::DGR_P_MISC_R; // [RQ1]
        dgr_pkg::PORT_GFX_IDX: port_o = dgr_pkg::DGR_P_GFX_IDX; // [RQ12]
        dgr_pkg::PORT_GFX_DATA: port_o = dgr_pkg::DGR_P_GFX_DATA; // [RQ12]
        default: port_o = dgr_pkg::DGR_P_NONE;
      endcase
    end
  end

endmodule

// ===== hw/dgr_general_regs.sv
`timescale 1ns/1ps
// Operation
// [RQ1] misc control written one port, read another
// [RQ2] range bit moves timing-controller index/data ports
// [RQ3] range bit moves status-one and feature ports
// [RQ4] bit one gates host video memory cycles
// [RQ5] bits 3:2 pick dot clock source
// [RQ6] bit five picks 64KB page unless locked
// [RQ7] status zero bit seven shows retrace interrupt
// [RQ8] status zero bit four shows monitor sense
// [RQ9] status one bit three shows vertical retrace
// [RQ10] status one bit zero shows display off
// [RQ11] status one bits 5:4 show pixel pair
// [RQ12] extended registers at graphics indexes 09-0f
// [RQ13] attribute shared write port, sequencer pair
// [RQ14] subsystem enable port lives outside this block
// [RQ15] configuration loaded at power-up, not written
// [RQ16] host writes zero to reserved bits
// [RQ17] feature bit three ors display enable into vsync
// [RQ18] misc control clears to zero on reset
// [RQ19] writes to read-only status ports are dropped
module dgr_general_regs (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire dgr_pkg::dgr_io_req_t io_req_i,
  input wire logic [7:0] cfg_strap_i,
  input wire logic retrace_irq_pending_i,
  input wire logic monitor_sense_input_i,
  input wire logic vretrace_i,
  input wire logic display_enable_i,
  input wire logic [7:0] pixel_out_i,
  input wire logic [1:0] plane_enable_i,
  input wire logic vsync_i,
  input wire logic vdisp_enable_i,
  input wire logic [7:0] grp_rdata_i,
  output logic [7:0] io_rdata_o,
  output logic io_rvalid_o,
  output logic io_hit_o,
  output dgr_pkg::dgr_grp_acc_t grp_acc_o,
  output dgr_pkg::dgr_dotclk_t dot_clk_sel_o,
  output logic mem_access_en_o,
  output logic page_upper_o,
  output logic crtc_color_o,
  output logic vsync_o,
  output logic [7:0] cfg_o
);

  dgr_pkg::dgr_port_t port;
  logic take_wr;
  logic take_rd;

  // register state
  logic [7:0] misc_reg, misc_next;
  logic [7:0] fc_reg, fc_next;
  logic [7:0] cfg_reg, cfg_next;
  logic cfg_loaded_reg, cfg_loaded_next;
  logic [7:0] seq_idx_reg, seq_idx_next;
  logic [7:0] crtc_idx_reg, crtc_idx_next;
  logic [7:0] gfx_idx_reg, gfx_idx_next;
  logic [7:0] attr_idx_reg, attr_idx_next;
  logic attr_data_phase_reg, attr_data_phase_next;
  logic [7:0] ext_reg [dgr_pkg::EXT_COUNT];
  logic [7:0] ext_next [dgr_pkg::EXT_COUNT];
  logic mon_sense_reg, mon_sense_next;

  // read pipeline and forwarded access
  logic rd_pend_reg, rd_pend_next;
  logic rd_ext_reg, rd_ext_next;
  logic [7:0] rd_local_reg, rd_local_next;
  dgr_pkg::dgr_grp_acc_t acc_reg, acc_next;
  logic [7:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;
  logic hit_reg, hit_next;

  // pin-facing outputs
  dgr_pkg::dgr_dotclk_t dotclk_reg, dotclk_next;
  logic mem_en_reg, mem_en_next;
  logic page_reg, page_next;
  logic color_reg, color_next;
  logic vsync_reg, vsync_next;

  // helpers
  logic gfx_ext_hit;
  logic [2:0] gfx_ext_slot;
  logic [7:0] memsize;
  logic [7:0] isr0_val;
  logic [7:0] isr1_val;
  logic diag_hi;
  logic diag_lo;

  dgr_port_decode u_decode (
    .addr_i(io_req_i.addr),
    .color_i(misc_reg[dgr_pkg::MISC_RANGE_BIT]),
    .port_o(port)
  );

  assign take_wr = io_req_i.wr;
  assign take_rd = io_req_i.rd & ~io_req_i.wr;

  // extended slot lookup; index 09 is slot 0
  always_comb begin
    gfx_ext_hit = (gfx_idx_reg >= dgr_pkg::EXT_IDX_FIRST) &&
      (gfx_idx_reg <= dgr_pkg::EXT_IDX_LAST); // [RQ12]
    gfx_ext_slot = 3'(gfx_idx_reg - dgr_pkg::EXT_IDX_FIRST);
    memsize = ext_reg[3'(dgr_pkg::EXT_IDX_MEMSIZE - dgr_pkg::EXT_IDX_FIRST)];
  end

  // status values are built live at the moment of the read, except monitor sense, taken from its register a cycle earlier
  always_comb begin
    case (plane_enable_i)
      2'h0: begin
        diag_hi = pixel_out_i[2];
        diag_lo = pixel_out_i[0];
      end
      2'h1: begin
        diag_hi = pixel_out_i[5];
        diag_lo = pixel_out_i[4];
      end
      2'h2: begin
        diag_hi = pixel_out_i[3];
        diag_lo = pixel_out_i[1];
      end
      default: begin
        diag_hi = pixel_out_i[7];
        diag_lo = pixel_out_i[6];
      end
    endcase
    isr0_val = 8'h00;
    isr0_val[dgr_pkg::ISR0_IRQ_BIT] = retrace_irq_pending_i; // [RQ7]
    isr0_val[dgr_pkg::ISR0_SENSE_BIT] = mon_sense_reg; // [RQ8]
    isr1_val = 8'h00;
    isr1_val[dgr_pkg::ISR1_DIAG_HI] = diag_hi; // [RQ11]
    isr1_val[dgr_pkg::ISR1_DIAG_LO] = diag_lo; // [RQ11]
    isr1_val[dgr_pkg::ISR1_VRETRACE_BIT] = vretrace_i; // [RQ9]
    isr1_val[dgr_pkg::ISR1_DISP_OFF_BIT] = ~display_enable_i; // [RQ10]
  end

  // host writes; misc reserved bits are stored as given, software keeps them zero; feature control masks its reserved bits to zero
  always_comb begin
    misc_next = misc_reg;
    fc_next = fc_reg;
    seq_idx_next = seq_idx_reg;
    crtc_idx_next = crtc_idx_reg;
    gfx_idx_next = gfx_idx_reg;
    attr_idx_next = attr_idx_reg;
    attr_data_phase_next = attr_data_phase_reg;
    for (int i = 0; i < dgr_pkg::EXT_COUNT; i++) begin
      ext_next[i] = ext_reg[i];
    end
    if (take_wr) begin
      case (port)
        dgr_pkg::DGR_P_MISC_W_ISR0: misc_next = io_req_i.wdata; // [RQ1] [RQ19]
        dgr_pkg::DGR_P_ISR1_FC_W: begin
          fc_next = io_req_i.wdata & dgr_pkg::FC_WR_MASK; // [RQ3] [RQ19]
        end
        dgr_pkg::DGR_P_SEQ_IDX: seq_idx_next = io_req_i.wdata; // [RQ13]
        dgr_pkg::DGR_P_CRTC_IDX: crtc_idx_next = io_req_i.wdata; // [RQ2]
        dgr_pkg::DGR_P_GFX_IDX: gfx_idx_next = io_req_i.wdata; // [RQ12]
        dgr_pkg::DGR_P_GFX_DATA: begin
          if (gfx_ext_hit) begin
            ext_next[gfx_ext_slot] = io_req_i.wdata; // [RQ12]
          end
        end
        dgr_pkg::DGR_P_ATTR_W: begin
          // one port, alternating index then data
          if (!attr_data_phase_reg) begin
            attr_idx_next = io_req_i.wdata; // [RQ13]
          end
          attr_data_phase_next = ~attr_data_phase_reg; // [RQ13]
        end
        default: begin
          // read-only and unmapped ports swallow writes
        end
      endcase
    end else if (take_rd && port == dgr_pkg::DGR_P_ISR1_FC_W) begin
      // reading status one rearms the attribute port at its index phase
      attr_data_phase_next = 1'b0;
    end
  end

  // power-on configuration: caught once, no host write path
  always_comb begin
    cfg_next = cfg_reg;
    cfg_loaded_next = 1'b1;
    if (!cfg_loaded_reg) begin
      cfg_next = cfg_strap_i; // [RQ15]
    end
    mon_sense_next = monitor_sense_input_i; // [RQ8]
  end

  // host reads and forwarded group accesses
  always_comb begin
    rd_pend_next = take_rd;
    rd_ext_next = 1'b0;
    rd_local_next = dgr_pkg::UNMAPPED_READ;
    hit_next = (take_rd | take_wr) && (port != dgr_pkg::DGR_P_NONE); // [RQ14]
    acc_next = '0;
    acc_next.grp = dgr_pkg::DGR_G_NONE;
    acc_next.wdata = io_req_i.wdata;
    if (take_rd) begin
      case (port)
        dgr_pkg::DGR_P_MISC_R: rd_local_next = misc_reg; // [RQ1]
        dgr_pkg::DGR_P_MISC_W_ISR0: rd_local_next = isr0_val; // [RQ7]
        dgr_pkg::DGR_P_ISR1_FC_W: rd_local_next = isr1_val; // [RQ9]
        dgr_pkg::DGR_P_FC_R: rd_local_next = fc_reg;
        dgr_pkg::DGR_P_SEQ_IDX: rd_local_next = seq_idx_reg;
        dgr_pkg::DGR_P_CRTC_IDX: rd_local_next = crtc_idx_reg;
        dgr_pkg::DGR_P_GFX_IDX: rd_local_next = gfx_idx_reg;
        dgr_pkg::DGR_P_ATTR_W: rd_local_next = attr_idx_reg;
        dgr_pkg::DGR_P_GFX_DATA: begin
          if (gfx_ext_hit) begin
            rd_local_next = ext_reg[gfx_ext_slot]; // [RQ12]
          end else begin
            rd_ext_next = 1'b1;
          end
        end
        dgr_pkg::DGR_P_SEQ_DATA, dgr_pkg::DGR_P_CRTC_DATA, dgr_pkg::DGR_P_ATTR_R: begin
          rd_ext_next = 1'b1; // [RQ13]
        end
        default: rd_local_next = dgr_pkg::UNMAPPED_READ;
      endcase
    end
    // group select for an outside data access
    case (port)
      dgr_pkg::DGR_P_SEQ_DATA: begin
        acc_next.grp = dgr_pkg::DGR_G_SEQ;
        acc_next.index = seq_idx_reg;
        acc_next.wr = take_wr;
        acc_next.rd = take_rd;
      end
      dgr_pkg::DGR_P_CRTC_DATA: begin
        acc_next.grp = dgr_pkg::DGR_G_CRTC;
        acc_next.index = crtc_idx_reg;
        acc_next.wr = take_wr;
        acc_next.rd = take_rd;
      end
      dgr_pkg::DGR_P_GFX_DATA: begin
        acc_next.grp = gfx_ext_hit ? dgr_pkg::DGR_G_NONE : dgr_pkg::DGR_G_GFX;
        acc_next.index = gfx_idx_reg;
        acc_next.wr = take_wr & ~gfx_ext_hit;
        acc_next.rd = take_rd & ~gfx_ext_hit;
      end
      dgr_pkg::DGR_P_ATTR_W: begin
        acc_next.grp = dgr_pkg::DGR_G_ATTR;
        acc_next.index = attr_idx_reg;
        acc_next.wr = take_wr & attr_data_phase_reg; // [RQ13]
      end
      dgr_pkg::DGR_P_ATTR_R: begin
        acc_next.grp = dgr_pkg::DGR_G_ATTR;
        acc_next.index = attr_idx_reg;
        acc_next.rd = take_rd; // [RQ13]
      end
      default: acc_next.grp = dgr_pkg::DGR_G_NONE;
    endcase
    // second stage: outside data arrives while acc_reg.rd is high
    rvalid_next = rd_pend_reg;
    rdata_next = rdata_reg;
    if (rd_pend_reg) begin
      rdata_next = rd_ext_reg ? grp_rdata_i : rd_local_reg;
    end
  end

  // pin controls follow the stored fields one cycle later
  always_comb begin
    color_next = misc_reg[dgr_pkg::MISC_RANGE_BIT]; // [RQ2]
    mem_en_next = misc_reg[dgr_pkg::MISC_MEM_EN_BIT]; // [RQ4]
    case (misc_reg[dgr_pkg::MISC_CLK_HI:dgr_pkg::MISC_CLK_LO])
      2'h0: dotclk_next = dgr_pkg::DGR_CLK_A; // [RQ5]
      2'h1: dotclk_next = dgr_pkg::DGR_CLK_B; // [RQ5]
      default: begin
        // a locked configuration keeps the user clock out
        dotclk_next = cfg_reg[dgr_pkg::CFG_CLK_LOCK_BIT] ? dgr_pkg::DGR_CLK_A
                                                         : dgr_pkg::DGR_CLK_USER; // [RQ5]
      end
    endcase
    // a large memory size setting overrides the page bit
    page_next = misc_reg[dgr_pkg::MISC_PAGE_BIT] &
      ~(memsize[dgr_pkg::MEMSIZE_PAGE_LOCK_HI] | memsize[dgr_pkg::MEMSIZE_PAGE_LOCK_LO]); // [RQ6]
    vsync_next = vsync_i |
      (fc_reg[dgr_pkg::FC_VSYNC_OR_BIT] & vdisp_enable_i); // [RQ17]
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      misc_reg <= dgr_pkg::MISC_RESET; // [RQ18]
      fc_reg <= dgr_pkg::FC_RESET;
      cfg_reg <= dgr_pkg::CFG_RESET;
      cfg_loaded_reg <= 1'b0; // [RQ15]
      seq_idx_reg <= dgr_pkg::IDX_RESET;
      crtc_idx_reg <= dgr_pkg::IDX_RESET;
      gfx_idx_reg <= dgr_pkg::IDX_RESET;
      attr_idx_reg <= dgr_pkg::IDX_RESET;
      attr_data_phase_reg <= 1'b0;
      for (int i = 0; i < dgr_pkg::EXT_COUNT; i++) begin
        ext_reg[i] <= dgr_pkg::EXT_RESET;
      end
      mon_sense_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      rd_ext_reg <= 1'b0;
      rd_local_reg <= 8'h00;
      acc_reg <= '0;
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
      hit_reg <= 1'b0;
      dotclk_reg <= dgr_pkg::DGR_CLK_A;
      mem_en_reg <= 1'b0;
      page_reg <= 1'b0;
      color_reg <= 1'b0;
      vsync_reg <= 1'b0;
    end else begin
      misc_reg <= misc_next;
      fc_reg <= fc_next;
      cfg_reg <= cfg_next;
      cfg_loaded_reg <= cfg_loaded_next;
      seq_idx_reg <= seq_idx_next;
      crtc_idx_reg <= crtc_idx_next;
      gfx_idx_reg <= gfx_idx_next;
      attr_idx_reg <= attr_idx_next;
      attr_data_phase_reg <= attr_data_phase_next;
      for (int i = 0; i < dgr_pkg::EXT_COUNT; i++) begin
        ext_reg[i] <= ext_next[i];
      end
      mon_sense_reg <= mon_sense_next;
      rd_pend_reg <= rd_pend_next;
      rd_ext_reg <= rd_ext_next;
      rd_local_reg <= rd_local_next;
      acc_reg <= acc_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
      hit_reg <= hit_next;
      dotclk_reg <= dotclk_next;
      mem_en_reg <= mem_en_next;
      page_reg <= page_next;
      color_reg <= color_next;
      vsync_reg <= vsync_next;
    end
  end

  assign io_rdata_o = rdata_reg;
  assign io_rvalid_o = rvalid_reg;
  assign io_hit_o = hit_reg;
  assign grp_acc_o = acc_reg;
  assign dot_clk_sel_o = dotclk_reg;
  assign mem_access_en_o = mem_en_reg;
  assign page_upper_o = page_reg;
  assign crtc_color_o = color_reg;
  assign vsync_o = vsync_reg;
  assign cfg_o = cfg_reg;

endmodule

// ===== dv/dgr_general_regs_properties.sv
`timescale 1ns/1ps
// watches host port and pin levels of the general register block
module dgr_general_regs_properties (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire dgr_pkg::dgr_io_req_t io_req_i,
  input wire logic retrace_irq_pending_i,
  input wire logic vretrace_i,
  input wire logic display_enable_i,
  input wire logic vsync_i,
  input wire logic vdisp_enable_i,
  input wire logic [7:0] io_rdata_o,
  input wire logic io_rvalid_o,
  input wire logic io_hit_o,
  input wire dgr_pkg::dgr_dotclk_t dot_clk_sel_o,
  input wire logic mem_access_en_o,
  input wire logic crtc_color_o,
  input wire logic vsync_o
);
  logic rst_d1_reg;
  logic rd_now;
  logic misc_wr;
  logic st1_rd;
  // vsync register is cleared one edge after reset
  always_ff @(posedge clk_sys_i) begin
    rst_d1_reg <= reset_i;
  end
  // request decode; write wins over read
  assign rd_now = io_req_i.rd && !io_req_i.wr;
  assign misc_wr = io_req_i.wr && (io_req_i.addr == dgr_pkg::PORT_MISC_W_ISR0);
  assign st1_rd = rd_now && (io_req_i.addr == dgr_pkg::PORT_ISR1_MONO ||
                             io_req_i.addr == dgr_pkg::PORT_ISR1_COLOR);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  read_answer_a: assert property (rd_now |-> ##2 io_rvalid_o)
    else $error("read not answered two cycles later");
  answer_cause_a: assert property (io_rvalid_o |-> $past(rd_now, 2))
    else $error("read answer without a request");
  range_bit_a: assert property (misc_wr
    |-> ##2 crtc_color_o == $past(io_req_i.wdata[0], 2))
    else $error("port range select does not follow write");
  mem_gate_a: assert property (misc_wr
    |-> ##2 mem_access_en_o == $past(io_req_i.wdata[1], 2))
    else $error("memory access gate does not follow write");
  clock_b_a: assert property (misc_wr && io_req_i.wdata[3:2] == 2'b01
    |-> ##2 dot_clk_sel_o == dgr_pkg::DGR_CLK_B) else $error("clock code one wrong");
  irq_bit_a: assert property (rd_now && io_req_i.addr == dgr_pkg::PORT_MISC_W_ISR0
    |-> ##1 io_hit_o ##1 io_rdata_o[7] == $past(retrace_irq_pending_i, 2))
    else $error("irq bit wrong");
  retrace_bit_a: assert property (st1_rd |=> (io_hit_o |=>
    io_rdata_o[3] == $past(vretrace_i, 2))) else $error("retrace bit wrong");
  display_off_a: assert property (st1_rd |=> (io_hit_o |=>
    io_rdata_o[0] == !$past(display_enable_i, 2))) else $error("display off bit wrong");
  vsync_pass_a: assert property (!rst_d1_reg && $past(vsync_i) |-> vsync_o)
    else $error("vsync dropped");
  vsync_quiet_a: assert property (!rst_d1_reg
    && !$past(vsync_i || vdisp_enable_i) |-> !vsync_o)
    else $error("vsync raised without cause");

  read_seen_c: cover property (rd_now ##2 io_rvalid_o);
  misc_write_c: cover property (misc_wr);
  status_hit_c: cover property (st1_rd ##1 io_hit_o);
endmodule

bind dgr_general_regs dgr_general_regs_properties dgr_general_regs_properties_i (
  .clk_sys_i(clk_sys_i), .reset_i(reset_i), .io_req_i(io_req_i),
  .retrace_irq_pending_i(retrace_irq_pending_i), .vretrace_i(vretrace_i),
  .display_enable_i(display_enable_i), .vsync_i(vsync_i), .vdisp_enable_i(vdisp_enable_i),
  .io_rdata_o(io_rdata_o), .io_rvalid_o(io_rvalid_o), .io_hit_o(io_hit_o),
  .dot_clk_sel_o(dot_clk_sel_o), .mem_access_en_o(mem_access_en_o),
  .crtc_color_o(crtc_color_o), .vsync_o(vsync_o)
);

// ===== dv/dgr_host_model.sv
`timescale 1ns/1ps
// byte-wide host i/o master: one access per call, one idle cycle after it
module dgr_host_model (
  input wire logic clk_sys_i,
  output dgr_pkg::dgr_io_req_t io_req_o
);
  initial io_req_o = '0;
  // drive after a falling edge, hold over the taking rising edge, then release
  task automatic io_access(input logic [15:0] addr, input logic wr, input logic [7:0] data);
    logic [7:0] d;
    d = data;
    if (wr && addr == dgr_pkg::PORT_MISC_W_ISR0) d[4] = 1'b0;
    @(negedge clk_sys_i);
    io_req_o = {addr, wr, !wr, d};
    @(negedge clk_sys_i);
    io_req_o = {~addr, 1'b0, 1'b0, ~d}; // released lines show no stale value
  endtask
endmodule

// ===== dv/test_display_general_register_port.sv
`timescale 1ns/1ps
// self-checking bench for the general register port
module test_display_general_register_port;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  dgr_pkg::dgr_io_req_t io_req;
  logic [7:0] cfg_strap = 8'h35;
  logic irq_pend = 1'b0;
  logic sense = 1'b0;
  logic vretrace = 1'b0;
  logic disp_en = 1'b1;
  logic [7:0] pixel = 8'h00;
  logic [1:0] plane = 2'b00;
  logic vsync = 1'b0;
  logic vdisp = 1'b0;
  logic [7:0] grp_rdata = 8'h00;
  logic [7:0] rdata;
  logic rvalid;
  logic hit;
  dgr_pkg::dgr_grp_acc_t grp_acc;
  dgr_pkg::dgr_dotclk_t dot_clk;
  logic mem_en;
  logic page_up;
  logic color;
  logic vsync_out;
  logic [7:0] cfg;
  logic [7:0] exp_q[$];
  logic [7:0] mask_q[$];
  logic [31:0] seed = 32'hfee83262;
  int bad_count = 0;
  int total_checks = 0;

  dgr_general_regs dgr_general_regs_i (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .io_req_i(io_req), .cfg_strap_i(cfg_strap),
    .retrace_irq_pending_i(irq_pend), .monitor_sense_input_i(sense), .vretrace_i(vretrace),
    .display_enable_i(disp_en), .pixel_out_i(pixel), .plane_enable_i(plane),
    .vsync_i(vsync), .vdisp_enable_i(vdisp), .grp_rdata_i(grp_rdata), .io_rdata_o(rdata),
    .io_rvalid_o(rvalid), .io_hit_o(hit), .grp_acc_o(grp_acc), .dot_clk_sel_o(dot_clk),
    .mem_access_en_o(mem_en), .page_upper_o(page_up), .crtc_color_o(color),
    .vsync_o(vsync_out), .cfg_o(cfg));
  dgr_host_model dgr_host_model_i (.clk_sys_i(clk_sys_i), .io_req_o(io_req));

  // 100 MHz
  always #5 clk_sys_i = ~clk_sys_i;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic rnd(output logic [7:0] v);
    seed = lfsr(seed);
    v = seed[7:0];
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    dgr_host_model_i.io_access(a, 1'b1, d);
  endtask
  // note first, so the watcher always finds it
  task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic [7:0] m);
    exp_q.push_back(e);
    mask_q.push_back(m);
    dgr_host_model_i.io_access(a, 1'b0, 8'h00);
  endtask
  task automatic settle;
    repeat (3) @(negedge clk_sys_i);
  endtask
  task automatic done(input string n);
    $display("test %s done", n);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // each answer takes the oldest note; sampled mid-cycle
  always @(negedge clk_sys_i) begin
    if (rvalid === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("unexpected read answer", 8'h01, 8'h00);
      end else begin
        check("read data", rdata & mask_q[0], exp_q[0] & mask_q[0]);
        void'(exp_q.pop_front());
        void'(mask_q.pop_front());
      end
    end
  end

  // cut a hang short; the whole run is a few hundred cycles
  initial begin
    repeat (5000) @(posedge clk_sys_i);
    bad_count++;
    $display("mismatch watchdog expected finish seen hang");
    end_of_test();
  end

  // main sequence
  initial begin
    logic [7:0] v;
    logic [7:0] px;
    logic [1:0] pair;
    logic [7:0] ext[7];
    dgr_pkg::dgr_dotclk_t ce;
    repeat (8) @(negedge clk_sys_i);
    reset_i = 1'b0;
    settle();
    check("config", cfg, 8'h35);
    done("reset");
    for (int c = 0; c < 4; c++) begin
      rnd(v);
      v = {v[7:6], c[1], 1'b0, c[1:0], ~c[0], 1'b0};
      ce = (c == 0) ? dgr_pkg::DGR_CLK_A : (c == 1) ? dgr_pkg::DGR_CLK_B : dgr_pkg::DGR_CLK_USER;
      wr(dgr_pkg::PORT_MISC_W_ISR0, v);
      settle();
      rd(dgr_pkg::PORT_MISC_R, v, 8'hff);
      check("clock source", 8'(dot_clk), 8'(ce));
      check("memory gate", {7'h0, mem_en}, {7'h0, v[1]});
      check("page", {7'h0, page_up}, {7'h0, v[5]});
      wr(dgr_pkg::PORT_MISC_R, ~v);
      rd(dgr_pkg::PORT_MISC_R, v, 8'hff);
    end
    done("misc control");
    for (int k = 0; k < 4; k++) begin
      irq_pend = k[0];
      sense = k[1];
      settle();
      rd(dgr_pkg::PORT_MISC_W_ISR0, {k[0], 2'b00, k[1], 4'h0}, 8'h90);
    end
    done("status zero");
    for (int b = 0; b < 2; b++) begin
      wr(dgr_pkg::PORT_MISC_W_ISR0, {7'h0, b[0]});
      settle();
      rnd(grp_rdata);
      rd(b ? 16'h03d5 : 16'h03b5, grp_rdata, 8'hff);
      rd(b ? 16'h03b5 : 16'h03d5, 8'h00, 8'hff);
      rd(b ? 16'h03ba : 16'h03da, 8'h00, 8'hff);
      for (int pe = 0; pe < 4; pe++) begin
        rnd(px);
        pixel = px;
        plane = pe[1:0];
        vretrace = px[0];
        disp_en = px[1];
        case (pe)
          0: pair = {px[2], px[0]};
          1: pair = {px[5], px[4]};
          2: pair = {px[3], px[1]};
          default: pair = {px[7], px[6]};
        endcase
        rd(b ? 16'h03da : 16'h03ba, {2'b00, pair, px[0], 2'b00, ~px[1]},
          8'h39);
      end
    end
    done("status one");
    wr(16'h03da, 8'h0b);
    rd(dgr_pkg::PORT_FC_R, 8'h0b, 8'hff);
    vdisp = 1'b1;
    settle();
    check("vsync or", {7'h0, vsync_out}, 8'h01);
    wr(16'h03da, 8'h00);
    wr(16'h03ba, 8'h08);
    wr(dgr_pkg::PORT_FC_R, 8'h08);
    settle();
    check("vsync normal", {7'h0, vsync_out}, 8'h00);
    vsync = 1'b1;
    settle();
    check("vsync pass", {7'h0, vsync_out}, 8'h01);
    done("feature control");
    for (int i = 9; i < 16; i++) begin
      rnd(ext[i-9]);
      wr(dgr_pkg::PORT_GFX_IDX, 8'(i));
      wr(dgr_pkg::PORT_GFX_DATA, ext[i-9]);
    end
    for (int i = 9; i < 16; i++) begin
      wr(dgr_pkg::PORT_GFX_IDX, 8'(i));
      rd(dgr_pkg::PORT_GFX_DATA, ext[i-9], 8'hff);
    end
    wr(dgr_pkg::PORT_GFX_IDX, 8'h0b);
    wr(dgr_pkg::PORT_GFX_DATA, 8'h00);
    wr(dgr_pkg::PORT_MISC_W_ISR0, 8'h21);
    settle();
    check("page free", {7'h0, page_up}, 8'h01);
    for (int j = 0; j < 2; j++) begin
      wr(dgr_pkg::PORT_GFX_DATA, j ? 8'h80 : 8'h40);
      settle();
      check("page locked", {7'h0, page_up}, 8'h00);
    end
    done("extended");
    wr(dgr_pkg::PORT_SEQ_IDX, 8'h03);
    rd(dgr_pkg::PORT_SEQ_IDX, 8'h03, 8'hff);
    rnd(grp_rdata);
    rd(dgr_pkg::PORT_SEQ_DATA, grp_rdata, 8'hff);
    rd(dgr_pkg::PORT_ATTR_R, grp_rdata, 8'hff);
    rd(16'h03da, 8'h00, 8'h00);
    wr(dgr_pkg::PORT_ATTR_W, 8'h12);
    wr(dgr_pkg::PORT_ATTR_W, 8'h5a);
    check("attr group", 8'(grp_acc.grp), 8'(dgr_pkg::DGR_G_ATTR));
    check("attr index", grp_acc.index, 8'h12);
    check("attr data", grp_acc.wr ? grp_acc.wdata : 8'hxx, 8'h5a);
    rd(16'h03c3, 8'h00, 8'hff);
    done("groups");
    settle();
    cfg_strap = 8'h08;
    reset_i = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    reset_i = 1'b0;
    settle();
    cfg_strap = 8'h00;
    rd(dgr_pkg::PORT_MISC_R, 8'h00, 8'hff);
    check("colour base", {7'h0, color}, 8'h00);
    wr(dgr_pkg::PORT_MISC_W_ISR0, 8'h0c);
    settle();
    check("clock locked", 8'(dot_clk), 8'(dgr_pkg::DGR_CLK_A));
    check("config kept", cfg, 8'h08);
    done("second reset");
    settle();
    check("reads left", 8'(exp_q.size()), 8'h00);
    end_of_test();
  end
endmodule
